//--- rtl/dcd_slave.sv
// two-wire slave holding the two current dac control registers
`timescale 1ns/10ps
module dcd_slave (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic       clk_en,
   // two-wire bus pins
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   // control registers toward the dacs
   output logic [7:0]      current_output_zero,
   output logic [7:0]      current_output_one,
   // effective drive per channel
   output logic            chan0_source,
   output logic            chan0_sink,
   output logic            chan1_source,
   output logic            chan1_sink
);
   import dcd_pkg::*;

   dcd_line_if ev ();

   dcd_state_t state_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] rx_q;
   logic [7:0] tx_q;
   logic [7:0] reg_ptr_q;
   logic       rd_more_q;
   logic [7:0] rx_byte;
   logic [7:0] rd_value;

   // register selector hit test, used for both read and write
   function automatic logic reg_hit(input logic [7:0] ptr, input logic [7:0] addr);
      reg_hit = (ptr == addr);
   endfunction : reg_hit

   // value returned for a read of the selected register
   function automatic logic [7:0] reg_read(input logic [7:0] ptr, input logic [7:0] r0,
                                           input logic [7:0] r1);
      if (reg_hit(ptr, REG_CUR_ZERO))
         reg_read = r0 & CTRL_MASK;
      else if (reg_hit(ptr, REG_CUR_ONE))
         reg_read = r1 & CTRL_MASK;
      else
         reg_read = CTRL_RESET;
   endfunction : reg_read

   dcd_line_watch u_watch (
      .sys_clk (sys_clk),
      .reset   (reset),
      .clk_en  (clk_en),
      .scl_i   (scl_i),
      .sda_i   (sda_i),
      .ev      (ev)
   );

   // eight received bits, msb first
   assign rx_byte = rx_q;

   // selected register as a read would return it
   assign rd_value = reg_read(reg_ptr_q, current_output_zero, current_output_one);

   // shift in on scl rising edge; the ninth bit is not shifted, so the
   // byte and its direction bit survive through the ack state
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rx_q <= CTRL_RESET;
      end else if (clk_en && ev.scl_rise && bit_cnt_q != BYTE_BITS) begin
         rx_q <= {rx_q[6:0], ev.sda};
      end
   end

   // bit counter: counts rising edges within a byte
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         bit_cnt_q <= CNT_ZERO;
      end else if (clk_en) begin
         if (ev.start || ev.stop)
            bit_cnt_q <= CNT_ZERO;
         else if (ev.scl_fall && state_q inside {DCD_ADDR_ACK, DCD_REG_ACK, DCD_WDATA_ACK, DCD_RDATA_ACK})
            bit_cnt_q <= CNT_ZERO;
         else if (ev.scl_rise && bit_cnt_q != BYTE_BITS)
            bit_cnt_q <= bit_cnt_q + CNT_ONE;
      end
   end

   // main sequencer
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q <= DCD_IDLE;
      end else if (clk_en) begin
         if (ev.stop) begin
            state_q <= DCD_IDLE;
         end else if (ev.start) begin
            state_q <= DCD_ADDR;
         end else if (ev.scl_fall) begin
            case (state_q)
               DCD_ADDR: begin
                  if (bit_cnt_q == BYTE_BITS) begin
                     if (rx_byte[7:1] == DEV_ADDR7)
                        state_q <= DCD_ADDR_ACK;
                     else
                        state_q <= DCD_IGNORE;
                  end
               end
               DCD_ADDR_ACK: begin
                  state_q <= rx_byte[0] ? DCD_RDATA : DCD_REG;
               end
               DCD_REG: begin
                  if (bit_cnt_q == BYTE_BITS)
                     state_q <= DCD_REG_ACK;
               end
               DCD_REG_ACK:   state_q <= DCD_WDATA;
               DCD_WDATA: begin
                  if (bit_cnt_q == BYTE_BITS)
                     state_q <= DCD_WDATA_ACK;
               end
               DCD_WDATA_ACK: state_q <= DCD_WDATA;
               DCD_RDATA: begin
                  if (bit_cnt_q == BYTE_BITS)
                     state_q <= DCD_RDATA_ACK;
               end
               DCD_RDATA_ACK: state_q <= rd_more_q ? DCD_RDATA : DCD_IGNORE;
               DCD_IDLE:      state_q <= DCD_IDLE;
               DCD_IGNORE:    state_q <= DCD_IGNORE;
               default:       state_q <= DCD_IDLE;
            endcase
         end
      end
   end

   // master acknowledge of a read byte sampled on the ninth rising edge
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rd_more_q <= 1'b0;
      end else if (clk_en && ev.scl_rise && state_q == DCD_RDATA_ACK) begin
         rd_more_q <= ~ev.sda;
      end
   end

   // register selector; rx_q still holds the byte while in the ack state
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         reg_ptr_q <= REG_CUR_ZERO;
      end else if (clk_en && ev.scl_fall && state_q == DCD_REG && bit_cnt_q == BYTE_BITS) begin
         reg_ptr_q <= rx_byte;
      end
   end

   // control registers; unmapped writes still acked, just dropped
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         current_output_zero <= CTRL_RESET;
         current_output_one  <= CTRL_RESET;
      end else if (clk_en && ev.scl_fall && state_q == DCD_WDATA && bit_cnt_q == BYTE_BITS) begin
         if (reg_hit(reg_ptr_q, REG_CUR_ZERO))
            current_output_zero <= rx_byte & CTRL_MASK;
         if (reg_hit(reg_ptr_q, REG_CUR_ONE))
            current_output_one <= rx_byte & CTRL_MASK;
      end
   end

   // effective drive: zero magnitude means no current whichever sign
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         chan0_source <= 1'b0;
         chan0_sink   <= 1'b0;
         chan1_source <= 1'b0;
         chan1_sink   <= 1'b0;
      end else if (clk_en) begin
         chan0_source <= current_output_zero[SIGN_POS]
                         & (current_output_zero[MAG_MSB:MAG_LSB] != MAG_ZERO);
         chan0_sink   <= ~current_output_zero[SIGN_POS]
                         & (current_output_zero[MAG_MSB:MAG_LSB] != MAG_ZERO);
         chan1_source <= current_output_one[SIGN_POS]
                         & (current_output_one[MAG_MSB:MAG_LSB] != MAG_ZERO);
         chan1_sink   <= ~current_output_one[SIGN_POS]
                         & (current_output_one[MAG_MSB:MAG_LSB] != MAG_ZERO);
      end
   end

   // transmit shift: load at the address ack end or after a master ack
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         tx_q <= CTRL_RESET;
      end else if (clk_en && ev.scl_fall) begin
         if ((state_q == DCD_ADDR_ACK && rx_byte[0]) || (state_q == DCD_RDATA_ACK && rd_more_q))
            tx_q <= rd_value;
         else if (state_q == DCD_RDATA && bit_cnt_q != BYTE_BITS)
            tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   // pin driver: only ever pulls low, changed on scl falling edges, else only released at a start or stop
   // so sda never moves while scl is high and cannot fake a start or stop
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sda_o  <= 1'b0;
         sda_oe <= 1'b0;
      end else if (clk_en) begin
         sda_o <= 1'b0;
         if (ev.start || ev.stop) begin
            sda_oe <= 1'b0;
         end else if (ev.scl_fall) begin
            case (state_q)
               DCD_ADDR:
                  sda_oe <= (bit_cnt_q == BYTE_BITS) && (rx_byte[7:1] == DEV_ADDR7);
               DCD_REG, DCD_WDATA:
                  sda_oe <= (bit_cnt_q == BYTE_BITS);
               DCD_ADDR_ACK: begin
                  if (rx_byte[0])
                     sda_oe <= ~rd_value[BYTE_MSB];
                  else
                     sda_oe <= 1'b0;
               end
               DCD_RDATA: begin
                  if (bit_cnt_q == BYTE_BITS)
                     sda_oe <= 1'b0; // master owns ninth bit
                  else
                     sda_oe <= ~tx_q[BYTE_MSB - 1];
               end
               DCD_RDATA_ACK: begin
                  if (rd_more_q)
                     sda_oe <= ~rd_value[BYTE_MSB];
                  else
                     sda_oe <= 1'b0;
               end
               DCD_REG_ACK, DCD_WDATA_ACK, DCD_IDLE, DCD_IGNORE:
                  sda_oe <= 1'b0;
               default:
                  sda_oe <= 1'b0;
            endcase
         end
      end
   end
endmodule : dcd_slave

//--- rtl/dcd_pkg.sv
// constants for the dual current dac two-wire slave
// How it works
// - every byte is followed by a ninth acknowledge bit from the receiver
// - receiver drives zero to acknowledge, leaves one to refuse
// - the acknowledge bit uses the same timing as any data bit
// - write byte is eight bits msb first, then slave acknowledges
// - read byte is eight bits msb first from slave; master acknowledges for more
// - master refuses last read byte; slave then releases the data line
// - first byte after start holds seven address bits and a direction bit
// - device answers address byte 90h, its fixed seven bit address
// - direction 0 means master writes, direction 1 (91h) means master reads
// - on address mismatch ignore the bus until the next start
// - byte after address in a write selects the register to store into
// - slave acknowledges every written byte, master samples it
// - output control registers sit at F8h and F9h
// - top bit picks source or sink, bits 3..0 magnitude, 6..4 reserved
// - zero magnitude gives no current; both fields clear at power-up
// - sample on rising scl edge, change read bits after falling edge
package dcd_pkg;
   localparam logic [6:0] DEV_ADDR7    = 7'h48;
   localparam logic [7:0] REG_CUR_ZERO = 8'hF8;
   localparam logic [7:0] REG_CUR_ONE  = 8'hF9;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] CTRL_MASK    = 8'h8F;
   localparam logic [3:0] BYTE_BITS    = 4'h8;
   localparam logic [3:0] CNT_ZERO     = 4'h0;
   localparam logic [3:0] CNT_ONE      = 4'h1;
   localparam logic [3:0] MAG_ZERO     = 4'h0;
   localparam int         SIGN_POS     = 7;
   localparam int         MAG_MSB      = 3;
   localparam int         MAG_LSB      = 0;
   localparam int         BYTE_MSB     = 7;

   typedef enum logic [3:0] {
      DCD_IDLE      = 4'h0,
      DCD_ADDR      = 4'h1,
      DCD_ADDR_ACK  = 4'h2,
      DCD_REG       = 4'h3,
      DCD_REG_ACK   = 4'h4,
      DCD_WDATA     = 4'h5,
      DCD_WDATA_ACK = 4'h6,
      DCD_RDATA     = 4'h7,
      DCD_RDATA_ACK = 4'h8,
      DCD_IGNORE    = 4'h9
   } dcd_state_t;
endpackage : dcd_pkg

//--- rtl/dcd_line_if.sv
// bus line events passed from the pin watcher to the slave engine
`timescale 1ns/10ps
interface dcd_line_if;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic sda;
   modport src (output scl_rise, output scl_fall, output start, output stop, output sda);
   modport snk (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface : dcd_line_if

//--- rtl/dcd_line_watch.sv
// synchronises scl and sda and finds edges, start and stop
`timescale 1ns/10ps
module dcd_line_watch (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic clk_en,
   // raw pins
   input  wire logic scl_i,
   input  wire logic sda_i,
   // events
   dcd_line_if.src   ev
);
   import dcd_pkg::*;

   logic [1:0] scl_meta_q;
   logic [1:0] sda_meta_q;
   logic       scl_prev_q;
   logic       sda_prev_q;

   // two stages per pin; idle bus is high so reset to one
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         scl_meta_q <= 2'h3;
         sda_meta_q <= 2'h3;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else if (clk_en) begin
         scl_meta_q <= {scl_meta_q[0], scl_i};
         sda_meta_q <= {sda_meta_q[0], sda_i};
         scl_prev_q <= scl_meta_q[1];
         sda_prev_q <= sda_meta_q[1];
      end
   end

   // edge and condition decode from settled stages only
   assign ev.sda      = sda_meta_q[1];
   assign ev.scl_rise = clk_en & scl_meta_q[1] & ~scl_prev_q;
   assign ev.scl_fall = clk_en & ~scl_meta_q[1] & scl_prev_q;
   assign ev.start    = clk_en & scl_meta_q[1] & scl_prev_q & ~sda_meta_q[1] & sda_prev_q;
   assign ev.stop     = clk_en & scl_meta_q[1] & scl_prev_q & sda_meta_q[1] & ~sda_prev_q;
endmodule : dcd_line_watch

//--- sim/dcd_slave_chk.sv
// pin-level assertions for the dual current dac slave
`timescale 1ns/10ps
module dcd_slave_chk (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       reset,
   input wire logic       clk_en,
   // bus pins
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe,
   // registers and drive
   input wire logic [7:0] current_output_zero,
   input wire logic [7:0] current_output_one,
   input wire logic       chan0_source,
   input wire logic       chan0_sink,
   input wire logic       chan1_source,
   input wire logic       chan1_sink
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // state seen just after reset lets go
   reset_clear_a: assert property ($fell(reset) |->
      !sda_oe && (current_output_zero | current_output_one) == 8'h00)
      else $error("registers or drive not clear after reset");
   // pull low only after scl has been low a while, like any data bit
   oe_rise_low_a: assert property ($rose(sda_oe) |-> !scl_i && $past(scl_i, 2) == 1'b0)
      else $error("data line taken while clock high");
   oe_hold_high_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
      else $error("data line moved during clock high");
   drive_zero_a: assert property (sda_oe |-> sda_o == 1'b0)
      else $error("driven level is not zero");
   reserved_zero_a: assert property ((current_output_zero[6:4] | current_output_one[6:4]) == 3'h0)
      else $error("reserved bits not zero");
   // zero magnitude means no drive either way
   chan0_map_a: assert property ({chan0_source, chan0_sink} == $past({current_output_zero[7], ~current_output_zero[7]}
      & {2{|current_output_zero[3:0]}}))
      else $error("channel zero drive wrong");
   chan1_map_a: assert property ({chan1_source, chan1_sink} == $past({current_output_one[7], ~current_output_one[7]}
      & {2{|current_output_one[3:0]}}))
      else $error("channel one drive wrong");
   // register zero only changes together with its data acknowledge, register one only while scl is low
   reg_ack_tie_a: assert property ($changed(current_output_zero) |-> ##[0:2] sda_oe)
      else $error("register changed without acknowledge");
   reg_scl_low_a: assert property ($changed(current_output_one) |-> !scl_i)
      else $error("register changed during clock high");
   cover property ($rose(sda_oe));
   cover property ($changed(current_output_one));
   cover property ($rose(chan0_sink));
   cover property ($rose(chan1_source));
endmodule : dcd_slave_chk

bind dcd_slave dcd_slave_chk chk (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .current_output_zero(current_output_zero), .current_output_one(current_output_one),
   .chan0_source(chan0_source), .chan0_sink(chan0_sink), .chan1_source(chan1_source), .chan1_sink(chan1_sink));

//--- sim/dcd_master_model.sv
// two-wire bus master model; released lines float high by pull-up
`timescale 1ns/10ps
module dcd_master_model (
   // clock
   input wire logic sys_clk,
   // bus
   input wire logic sda_w,
   output logic     scl,
   output logic     sda_m
);
   localparam int HALF = 8;
   // idle bus at power-up
   initial begin
      scl   = 1'b1;
      sda_m = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   // data moves mid low phase, sampled at the end of the high phase
   task automatic bit_x(input logic b, output logic r);
      tick(HALF / 2);
      sda_m <= b;
      tick(HALF / 2);
      scl <= 1'b1;
      tick(HALF);
      r = sda_w;
      scl <= 1'b0;
   endtask : bit_x
   // data line high in the low phase, then falls while the clock is high
   task automatic start;
      tick(HALF / 2);
      sda_m <= 1'b1;
      tick(HALF / 2);
      scl <= 1'b1;
      tick(HALF);
      sda_m <= 1'b0;
      tick(HALF);
      scl <= 1'b0;
   endtask : start
   // data line low in the low phase, then rises while the clock is high
   task automatic stop;
      tick(HALF / 2);
      sda_m <= 1'b0;
      tick(HALF / 2);
      scl <= 1'b1;
      tick(HALF);
      sda_m <= 1'b1;
      tick(HALF);
   endtask : stop
   // byte out msb first, then sample the ninth bit
   task automatic wr(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, ack);
   endtask : wr
   // byte in msb first, then acknowledge or refuse
   task automatic rd(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(nack, r);
   endtask : rd
   task automatic xfer_write(input logic [7:0] adr, rg, dt, output logic [2:0] acks);
      start;
      wr(adr, acks[2]);
      wr(rg, acks[1]);
      wr(dt, acks[0]);
      stop;
   endtask : xfer_write
   task automatic xfer_read(input logic [7:0] adr, output logic [7:0] d, output logic ack);
      start;
      wr(adr, ack);
      rd(1'b1, d);
      stop;
   endtask : xfer_read
endmodule : dcd_master_model

//--- sim/dcd_slave_tb.sv
// self-checking bench for the dual current dac two-wire slave
`timescale 1ns/10ps
module dcd_slave_tb;
   import dcd_pkg::*;
   typedef struct packed {logic [7:0] rg, dt, x0, x1, xr;} dcd_row_t;
   logic       sys_clk, reset, clk_en, scl, sda_m, sda_o, sda_oe, ack;
   logic       c0src, c0snk, c1src, c1snk;
   logic [7:0] cur0, cur1, rd_q;
   logic [2:0] acks;
   int         errors = 0;
   int         checks_done = 0;
   wire        sda_w = sda_m & ~sda_oe;
   // reg, data, expected cur0, cur1, read-back; last row leaves f9h selected
   dcd_row_t rows [6] = '{'{8'hF8, 8'h8A, 8'h8A, 8'h00, 8'h8A}, '{8'hF9, 8'h05, 8'h8A, 8'h05, 8'h05},
      '{8'h10, 8'h77, 8'h8A, 8'h05, 8'h00}, '{8'hF8, 8'h70, 8'h00, 8'h05, 8'h00},
      '{8'hF8, 8'h0F, 8'h0F, 8'h05, 8'h0F}, '{8'hF9, 8'hFF, 8'h0F, 8'h8F, 8'h8F}};
   dcd_slave uut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe(sda_oe), .current_output_zero(cur0), .current_output_one(cur1), .chan0_source(c0src),
      .chan0_sink(c0snk), .chan1_source(c1src), .chan1_sink(c1snk));
   dcd_master_model m (.sys_clk(sys_clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
   always #20 sys_clk = ~sys_clk;
   // expected {source, sink} of one control value
   function automatic logic [1:0] drive(input logic [7:0] r);
      return {r[7], ~r[7]} & {2{|r[3:0]}};
   endfunction : drive
   task automatic check(input string nm, input logic [7:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   // watchdog well beyond the expected run of about 7600 cycles
   initial begin
      repeat (40000) @(posedge sys_clk);
      errors++;
      report_and_stop;
   end
   initial begin
      sys_clk = 1'b0;
      reset   = 1'b1;
      clk_en  = 1'b1;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (4) @(posedge sys_clk);
      foreach (rows[i]) begin
         m.xfer_write(8'h90, rows[i].rg, rows[i].dt, acks);
         check("write acks", {5'h00, acks}, 8'h00);
         m.xfer_read(8'h91, rd_q, ack);
         check("read ack", {7'h00, ack}, 8'h00);
         check("read data", rd_q, rows[i].xr);
         check("cur0", cur0, rows[i].x0);
         check("cur1", cur1, rows[i].x1);
         check("drive", {4'h0, c0src, c0snk, c1src, c1snk}, {4'h0, drive(rows[i].x0), drive(rows[i].x1)});
      end
      // second reset in mid-run
      reset <= 1'b1;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check("reset regs", cur0 | cur1, 8'h00);
      // foreign address: nothing acknowledged, nothing stored
      m.xfer_write(8'hA0, 8'hF8, 8'h55, acks);
      check("foreign acks", {5'h00, acks}, 8'h07);
      check("foreign cur0", cur0, 8'h00);
      // master acknowledges the first byte, so the same register comes again
      m.xfer_write(8'h90, 8'hF9, 8'h83, acks);
      m.start;
      m.wr(8'h91, ack);
      m.rd(1'b0, rd_q);
      check("first byte", rd_q, 8'h83);
      m.rd(1'b1, rd_q);
      check("second byte", rd_q, 8'h83);
      m.stop;
      // select f8h without data, then repeated start and read
      m.start;
      m.wr(8'h90, ack);
      m.wr(8'hF8, ack);
      m.start;
      m.wr(8'h91, ack);
      m.rd(1'b1, rd_q);
      m.stop;
      check("selected read", rd_q, 8'h00);
      // two data bytes in one write land in the same register
      m.start;
      m.wr(8'h90, ack);
      m.wr(8'hF8, ack);
      m.wr(8'h01, ack);
      m.wr(8'h8C, ack);
      check("second data ack", {7'h00, ack}, 8'h00);
      m.stop;
      check("cur0 overwrite", cur0, 8'h8C);
      report_and_stop;
   end
endmodule : dcd_slave_tb
